/* File: design/malu_pkg.sv */
// Purpose: Shared constants and opcode type for the subtract/xor/swap datapath
// Assumes: 8-bit data, 7-bit file address
// Notes: Opcode codes are local to this block
package malu_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int NIB_HI = 7;
  localparam int NIB_LO = 3;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [2:0] PORT_SEL_FIRST = 3'h5;
  localparam logic [2:0] PORT_SEL_SECOND = 3'h6;
  localparam logic [2:0] PORT_SEL_THIRD = 3'h7;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [2:0] {
    MALU_OP_NONE = 3'b000,
    MALU_OP_SUB_FILE = 3'b001,
    MALU_OP_SUB_LIT = 3'b010,
    MALU_OP_SUB_BORROW = 3'b011,
    MALU_OP_NIB_EXCH = 3'b100,
    MALU_OP_DIR_LOAD = 3'b101,
    MALU_OP_XOR_LIT = 3'b110,
    MALU_OP_XOR_FILE = 3'b111
  } malu_op_t;
endpackage

/* File: design/malu_sub_unit.sv */
// Purpose: Combinational 8-bit subtractor with borrow-not flags
// Assumes: Minuend minus subtrahend minus inverted carry-in
// Notes: Carry-in is the borrow_not convention, 1 means no borrow
`timescale 1ns/1ps
module malu_sub_unit
  import malu_pkg::*;
(
  input wire logic [malu_pkg::DATA_W-1:0] minuend,
  input wire logic [malu_pkg::DATA_W-1:0] subtrahend,
  input wire logic carry_in,
  output logic [malu_pkg::DATA_W-1:0] diff,
  output logic borrow_not,
  output logic nibble_borrow_not
);
  import malu_pkg::*;

  logic [DATA_W:0] full_sum;
  logic [4:0] low_sum;

  // Add complement: carry out is exactly borrow_not
  always_comb
  begin
    full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {{DATA_W{1'b0}}, carry_in};
    low_sum = {1'b0, minuend[NIB_LO:0]} + {1'b0, ~subtrahend[NIB_LO:0]} + {4'h0, carry_in};
    diff = full_sum[DATA_W-1:0];
    borrow_not = full_sum[DATA_W];
    nibble_borrow_not = low_sum[4];
  end
endmodule

/* File: design/malu_core.sv */
// Purpose: Execute subtract, xor, nibble exchange and port direction loads
// Assumes: Decoder gives one-cycle op_valid with operands; file data is read data
// Notes: Results and flags registered one cycle after op_valid
//
// Function
// - File minus accumulator, destination bit, borrow flags
// - Literal minus accumulator into accumulator, flags
// - File minus accumulator minus inverted borrow_not
// - Source low nibble into result high nibble
// - Direction load copies accumulator, flags untouched
// - Operand 5,6,7 pick first/second/third direction
// - Literal xor accumulator, only zero flag
// - File xor accumulator, destination bit, zero flag
`timescale 1ns/1ps
module malu_core
  import malu_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire malu_pkg::malu_op_t op_code,
  input wire logic dest_sel,
  input wire logic [malu_pkg::ADDR_W-1:0] file_addr,
  input wire logic [malu_pkg::DATA_W-1:0] file_rdata,
  input wire logic [malu_pkg::DATA_W-1:0] literal,
  input wire logic [2:0] port_sel,
  input wire logic borrow_not_in,
  input wire logic nibble_borrow_not_in,
  input wire logic result_null_in,
  output logic [malu_pkg::DATA_W-1:0] acc,
  output logic file_we,
  output logic [malu_pkg::ADDR_W-1:0] file_waddr,
  output logic [malu_pkg::DATA_W-1:0] file_wdata,
  output logic borrow_not,
  output logic nibble_borrow_not,
  output logic result_null_flag,
  output logic flags_we,
  output logic [malu_pkg::DATA_W-1:0] first_port_direction,
  output logic [malu_pkg::DATA_W-1:0] second_port_direction,
  output logic [malu_pkg::DATA_W-1:0] third_port_direction,
  output logic bad_port_sel
);
  import malu_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] acc;
    logic file_we;
    logic [ADDR_W-1:0] file_waddr;
    logic [DATA_W-1:0] file_wdata;
    logic borrow_not;
    logic nibble_borrow_not;
    logic result_null;
    logic flags_we;
    logic [DATA_W-1:0] dir0;
    logic [DATA_W-1:0] dir1;
    logic [DATA_W-1:0] dir2;
    logic bad_sel;
  } malu_state_t;

  malu_state_t st_r;
  malu_state_t st_nxt;
  logic [DATA_W-1:0] sub_a;
  logic sub_cin;
  logic [DATA_W-1:0] sub_diff;
  logic sub_bn;
  logic sub_nbn;
  logic [DATA_W-1:0] result;
  logic write_result;

  // Only the borrow form feeds the live flag in; plain subtracts carry 1
  always_comb
  begin
    sub_a = (op_code == MALU_OP_SUB_LIT) ? literal : file_rdata;
    sub_cin = (op_code == MALU_OP_SUB_BORROW) ? borrow_not_in : 1'b1;
  end

  malu_sub_unit u_sub (
    .minuend(sub_a),
    .subtrahend(st_r.acc),
    .carry_in(sub_cin),
    .diff(sub_diff),
    .borrow_not(sub_bn),
    .nibble_borrow_not(sub_nbn)
  );

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.file_we = 1'b0;
    st_nxt.flags_we = 1'b0;
    st_nxt.bad_sel = 1'b0;
    result = sub_diff;
    write_result = 1'b0;
    if (op_valid)
    begin
      unique case (op_code)
        MALU_OP_SUB_FILE, MALU_OP_SUB_BORROW, MALU_OP_SUB_LIT:
        begin
          result = sub_diff;
          write_result = 1'b1;
          st_nxt.borrow_not = sub_bn;
          st_nxt.nibble_borrow_not = sub_nbn;
          st_nxt.result_null = (sub_diff == '0);
          st_nxt.flags_we = 1'b1;
        end
        MALU_OP_NIB_EXCH:
        begin
          result = {file_rdata[NIB_LO:0], file_rdata[NIB_HI:NIB_LO+1]};
          write_result = 1'b1;
        end
        MALU_OP_XOR_LIT, MALU_OP_XOR_FILE:
        begin
          result = st_r.acc ^ ((op_code == MALU_OP_XOR_LIT) ? literal : file_rdata);
          write_result = 1'b1;
          st_nxt.result_null = (result == '0);
          st_nxt.flags_we = 1'b1;
        end
        MALU_OP_DIR_LOAD:
        begin
          // Flags left alone; illegal selects ignored and reported
          unique case (port_sel)
            PORT_SEL_FIRST: st_nxt.dir0 = st_r.acc;
            PORT_SEL_SECOND: st_nxt.dir1 = st_r.acc;
            PORT_SEL_THIRD: st_nxt.dir2 = st_r.acc;
            default: st_nxt.bad_sel = 1'b1;
          endcase
        end
        MALU_OP_NONE:
        begin
          write_result = 1'b0;
        end
      endcase
      if (write_result)
      begin
        // Literal ops always land in the accumulator
        if (dest_sel == DEST_FILE && op_code != MALU_OP_SUB_LIT && op_code != MALU_OP_XOR_LIT)
        begin
          st_nxt.file_we = 1'b1;
          st_nxt.file_waddr = file_addr;
          st_nxt.file_wdata = result;
        end
        else
        begin
          st_nxt.acc = result;
        end
      end
    end
    if (!st_nxt.flags_we)
    begin
      // Mirror live status so the outputs never go stale
      st_nxt.borrow_not = borrow_not_in;
      st_nxt.nibble_borrow_not = nibble_borrow_not_in;
      st_nxt.result_null = result_null_in;
    end
    else if (op_code == MALU_OP_XOR_LIT || op_code == MALU_OP_XOR_FILE)
    begin
      st_nxt.borrow_not = borrow_not_in;
      st_nxt.nibble_borrow_not = nibble_borrow_not_in;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.acc <= ACC_RST;
      st_r.dir0 <= DIR_RST;
      st_r.dir1 <= DIR_RST;
      st_r.dir2 <= DIR_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign acc = st_r.acc;
  assign file_we = st_r.file_we;
  assign file_waddr = st_r.file_waddr;
  assign file_wdata = st_r.file_wdata;
  assign borrow_not = st_r.borrow_not;
  assign nibble_borrow_not = st_r.nibble_borrow_not;
  assign result_null_flag = st_r.result_null;
  assign flags_we = st_r.flags_we;
  assign first_port_direction = st_r.dir0;
  assign second_port_direction = st_r.dir1;
  assign third_port_direction = st_r.dir2;
  assign bad_port_sel = st_r.bad_sel;

  a_sub_file_result: assert property (@(posedge core_clk) disable iff (!rst_n)
    op_valid && op_code == MALU_OP_SUB_FILE && dest_sel == DEST_ACC
    |=> acc == $past(file_rdata) - $past(acc) && borrow_not == ($past(acc) <= $past(file_rdata)))
    else $error("subtract from file wrong");
  a_sub_lit_result: assert property (@(posedge core_clk) disable iff (!rst_n)
    op_valid && op_code == MALU_OP_SUB_LIT
    |=> acc == $past(literal) - $past(acc) && !file_we
    && nibble_borrow_not == ($past(acc[3:0]) <= $past(literal[3:0])))
    else $error("literal subtract wrong");
  a_sub_borrow_val: assert property (@(posedge core_clk) disable iff (!rst_n)
    op_valid && op_code == MALU_OP_SUB_BORROW && dest_sel == DEST_FILE
    |=> file_we && file_wdata == $past(file_rdata) - $past(acc) - {7'h0, !$past(borrow_not_in)})
    else $error("borrow subtract wrong");
  a_nib_exch_swap: assert property (@(posedge core_clk) disable iff (!rst_n)
    op_valid && op_code == MALU_OP_NIB_EXCH && dest_sel == DEST_ACC
    |=> acc[7:4] == $past(file_rdata[3:0]) && acc[3:0] == $past(file_rdata[7:4]))
    else $error("nibble exchange wrong");
  a_dir_load_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
    op_valid && op_code == MALU_OP_DIR_LOAD |=> !flags_we && $stable(acc))
    else $error("direction load touched state");
  a_dir_first_sel: assert property (@(posedge core_clk) disable iff (!rst_n)
    op_valid && op_code == MALU_OP_DIR_LOAD && port_sel == PORT_SEL_FIRST
    |=> first_port_direction == $past(acc) && $stable(second_port_direction))
    else $error("first direction select wrong");
  a_xor_lit_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
    op_valid && op_code == MALU_OP_XOR_LIT
    |=> acc == ($past(acc) ^ $past(literal)) && borrow_not == $past(borrow_not_in))
    else $error("literal xor wrong");
  a_xor_file_dest: assert property (@(posedge core_clk) disable iff (!rst_n)
    op_valid && op_code == MALU_OP_XOR_FILE && dest_sel == DEST_FILE
    |=> file_we && file_waddr == $past(file_addr) && $stable(acc))
    else $error("file xor destination wrong");
  a_zero_flag_val: assert property (@(posedge core_clk) disable iff (!rst_n)
    flags_we && !file_we |-> result_null_flag == (acc == 8'h00))
    else $error("zero flag mismatch");
  c_sub_borrow: cover property (@(posedge core_clk) op_valid && op_code == MALU_OP_SUB_BORROW);
  c_dir_third: cover property (@(posedge core_clk)
    op_valid && op_code == MALU_OP_DIR_LOAD && port_sel == PORT_SEL_THIRD);
  c_zero_result: cover property (@(posedge core_clk) flags_we && result_null_flag);
endmodule

/* File: verif/malu_file_model.sv */
// Purpose: Far-side model of file registers and status register
// Assumes: Reads are combinational, writes land on the edge that sees a pulse
// Notes: Contents seeded from the address so the bench can predict them
`timescale 1ns/1ps
module malu_file_model
  import malu_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [malu_pkg::ADDR_W-1:0] file_addr,
  output logic [malu_pkg::DATA_W-1:0] file_rdata,
  input wire logic file_we,
  input wire logic [malu_pkg::ADDR_W-1:0] file_waddr,
  input wire logic [malu_pkg::DATA_W-1:0] file_wdata,
  input wire logic flags_we,
  input wire logic borrow_not,
  input wire logic nibble_borrow_not,
  input wire logic result_null_flag,
  output logic borrow_not_in,
  output logic nibble_borrow_not_in,
  output logic result_null_in
);
  logic [DATA_W-1:0] mem [128];

  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 8'(i * 37 + 17);
  end

  assign file_rdata = mem[file_addr];

  // Status only moves on flags_we, never on the mirrored values
  always @(posedge core_clk)
  begin
    if (!rst_n)
      {borrow_not_in, nibble_borrow_not_in, result_null_in} <= 3'h0;
    else if (flags_we)
      {borrow_not_in, nibble_borrow_not_in, result_null_in} <=
        {borrow_not, nibble_borrow_not, result_null_flag};
    if (rst_n && file_we)
      mem[file_waddr] <= file_wdata;
  end
endmodule

/* File: verif/mcu_alu_subtract_xor_swap_ops_tb.sv */
// Purpose: Self-checking bench for the subtract/xor/swap datapath
// Assumes: One idle cycle between ops so file and status writes land
// Notes: Shadow state predicts every result; random ops mixed with corners
`timescale 1ns/1ps
module mcu_alu_subtract_xor_swap_ops_tb;
  import malu_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n, op_valid, dest_sel, borrow_not_in, nibble_borrow_not_in, result_null_in;
  malu_op_t op_code;
  logic [6:0] file_addr, file_waddr;
  logic [7:0] file_rdata, literal, acc, file_wdata;
  logic [2:0] port_sel;
  logic file_we, borrow_not, nibble_borrow_not, result_null_flag, flags_we, bad_port_sel;
  logic [7:0] first_port_direction, second_port_direction, third_port_direction;
  logic [7:0] mem_s [128];
  logic [7:0] acc_s;
  logic [23:0] dir_s;
  logic c_s, nb_s, z_s;
  logic [31:0] r;
  integer seed, err_count = 0, n_tests = 0, cycles = 0;

  malu_core dut (.*);
  malu_file_model partner (.*);

  always #12.5 core_clk = ~core_clk;

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic run_op(input malu_op_t op, input logic d, input logic [6:0] a,
                        input logic [7:0] k, input logic [2:0] ps);
    logic [8:0] t;
    logic [4:0] n;
    logic [7:0] m, res;
    logic b, fw, fl, bad;
    m = (op == MALU_OP_SUB_LIT) ? k : mem_s[a];
    res = acc_s;
    {fl, bad} = 2'b10;
    b = (op == MALU_OP_SUB_BORROW) ? !c_s : 1'b0;
    case (op)
      MALU_OP_SUB_FILE, MALU_OP_SUB_LIT, MALU_OP_SUB_BORROW:
      begin
        t = {1'b0, m} - {1'b0, acc_s} - 9'(b);
        n = {1'b0, m[3:0]} - {1'b0, acc_s[3:0]} - 5'(b);
        res = t[7:0];
        {c_s, nb_s} = {!t[8], !n[4]};
      end
      MALU_OP_NIB_EXCH: {res, fl} = {m[3:0], m[7:4], 1'b0};
      MALU_OP_XOR_LIT: res = acc_s ^ k;
      MALU_OP_XOR_FILE: res = acc_s ^ m;
      MALU_OP_DIR_LOAD:
      begin
        fl = 1'b0;
        case (ps)
          3'h5: dir_s[23:16] = acc_s;
          3'h6: dir_s[15:8] = acc_s;
          3'h7: dir_s[7:0] = acc_s;
          default: bad = 1'b1;
        endcase
      end
      default: fl = 1'b0;
    endcase
    if (fl)
      z_s = (res == 8'h00);
    fw = d && (op inside {MALU_OP_SUB_FILE, MALU_OP_SUB_BORROW, MALU_OP_NIB_EXCH,
                          MALU_OP_XOR_FILE});
    if (fw)
      mem_s[a] = res;
    else if (!(op inside {MALU_OP_DIR_LOAD, MALU_OP_NONE}))
      acc_s = res;
    @(posedge core_clk);
    {op_valid, dest_sel, file_addr, literal, port_sel} <= {1'b1, d, a, k, ps};
    op_code <= op;
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1;
    check(24'(acc), 24'(acc_s));
    check(24'(file_we), 24'(fw));
    // Address and data hold their last write; only meaningful with the strobe
    if (fw)
      check(24'({file_waddr, file_wdata}), 24'({a, res}));
    check(24'({borrow_not, nibble_borrow_not, result_null_flag}),
          24'({c_s, nb_s, z_s}));
    check(24'({flags_we, bad_port_sel}), 24'({fl, bad}));
    check({first_port_direction, second_port_direction, third_port_direction}, dir_s);
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    // Expected run is about 430 cycles
    if (cycles == 2000)
    begin
      err_count++;
      wrap_up();
    end
  end

  initial
  begin
    {rst_n, op_valid, dest_sel, file_addr, literal, port_sel} = '0;
    op_code = MALU_OP_NONE;
    seed = 32'h4a7f06d8;
    {acc_s, dir_s, c_s, nb_s, z_s} = {ACC_RST, {3{DIR_RST}}, 3'h0};
    for (int i = 0; i < 128; i++)
      mem_s[i] = 8'(i * 37 + 17);
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    check(24'(acc), 24'(ACC_RST));
    check({first_port_direction, second_port_direction, third_port_direction}, {3{DIR_RST}});
    // Boundaries: equal operands, W above k, borrow chained in, swap read back
    run_op(MALU_OP_XOR_LIT, 1'b0, 7'h00, 8'h03, 3'h0);
    run_op(MALU_OP_SUB_LIT, 1'b0, 7'h00, 8'h03, 3'h0);
    run_op(MALU_OP_XOR_LIT, 1'b0, 7'h00, 8'h01, 3'h0);
    run_op(MALU_OP_SUB_LIT, 1'b0, 7'h00, 8'h00, 3'h0);
    run_op(MALU_OP_SUB_BORROW, 1'b1, 7'h05, 8'h00, 3'h0);
    run_op(MALU_OP_NIB_EXCH, 1'b1, 7'h05, 8'h00, 3'h0);
    run_op(MALU_OP_NIB_EXCH, 1'b0, 7'h05, 8'h00, 3'h0);
    for (int p = 4; p < 8; p++)
      run_op(MALU_OP_DIR_LOAD, 1'b0, 7'h00, 8'h00, 3'(p));
    run_op(MALU_OP_XOR_FILE, 1'b1, 7'h7f, 8'h00, 3'h0);
    run_op(MALU_OP_SUB_FILE, 1'b0, 7'h00, 8'h00, 3'h0);
    for (int i = 0; i < 200; i++)
    begin
      r = $random(seed);
      run_op(malu_op_t'(r[2:0]), r[3], r[10:4], r[18:11], 3'h4 + 3'(r[20:19]));
    end
    wrap_up();
  end
endmodule
